// File: mid_core.sv
`timescale 1ns/10ps
`include "mid_defs.svh"
module mid_core
   import mid_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire mid_word_t progData,
   input wire logic [7:0] regRdData,
   input wire mid_addr_t tblPtr,
   input wire logic wakeUp,
   input wire logic wdtTimeout,
   output mid_addr_t progAddr_r,
   output logic [6:0] regRdAddr_r,
   output logic regWrEn_r,
   output logic [6:0] regWrAddr_r,
   output logic [7:0] regWrData_r,
   output logic rplWrEn_r,
   output logic [5:0] rplWrAddr_r,
   output logic [7:0] acc_r,
   output logic carry_r,
   output logic halfCarry_r,
   output logic zero_r,
   output logic timeoutFlag_r,
   output logic powerDownFlag_r,
   output logic sleepMode_r,
   output logic wdtClear_r,
   output logic globalIrqEnable_r
);
   // ==========================================
   // state
   mid_state_t state_r;
   mid_state_t state_nxt;
   mid_word_t ir_r;
   mid_addr_t savePc_r;
   logic tabHi_r;

   mid_stack_if stk ();

   mid_stack u_stack (
      .clk(clk),
      .rst_n(rst_n),
      .stk(stk)
   );

   // ==========================================
   // field decode
   wire [1:0] grp = ir_r[13:12];
   wire [3:0] fn = ir_r[11:8];
   wire dBit = ir_r[7];
   wire [7:0] lit = ir_r[7:0];
   wire [1:0] bitOp = ir_r[10:9];
   wire [2:0] bitNum = ir_r[8:6];
   wire exec = state_r == ST_EXEC;
   wire grpByte = grp == `MID_GRP_BYTE;
   wire grpBit = grp == `MID_GRP_BIT && !ir_r[11];
   wire grpLit = grp == `MID_GRP_BIT && ir_r[11];
   wire isCall = grp == `MID_GRP_CALL;
   wire isJump = grp == `MID_GRP_JUMP;
   wire isRetlw = grpLit && fn == `MID_L_RETURN_WITH_LITERAL;
   wire isRet = ir_r == `MID_RET || ir_r == `MID_INTERRUPT_RETURN || isRetlw;
   wire isTab = ir_r == `MID_TABLE_READ_HIGH || ir_r == `MID_TABLE_READ_LOW;
   wire isSleep = ir_r == `MID_SLEEP;
   wire isWdt = ir_r == `MID_WDTCLR;
   // fixed encodings win over the R-plane move with the same bits
   wire isMovwr = ir_r[13:6] == 8'h00 && ir_r != `MID_NOP && !isSleep
      && !isWdt;

   // ==========================================
   // operand with bypass of the write still in flight
   wire fwd = regWrEn_r && regWrAddr_r == regRdAddr_r;
   wire [7:0] opnd = fwd ? regWrData_r : regRdData;

   // ==========================================
   // adder shared by all add and subtract forms
   wire isSub = (grpByte && fn == `MID_F_SUB)
      || (grpLit && fn == `MID_L_SUB);
   wire [7:0] aSel = grpLit ? lit : opnd;
   wire [7:0] bSel = isSub ? ~acc_r : acc_r;
   wire [8:0] sum = {1'b0, aSel} + {1'b0, bSel} + {8'h00, isSub};
   wire [4:0] nib = {1'b0, aSel[3:0]} + {1'b0, bSel[3:0]}
      + {4'h0, isSub};
   wire [7:0] incVal = opnd + 8'h01;
   wire [7:0] decVal = opnd - 8'h01;
   wire [7:0] bitMask = 8'h01 << bitNum;
   wire bitVal = |(opnd & bitMask);

   // ==========================================
   // result and effects
   logic [7:0] res;
   logic toAcc;
   logic toReg;
   logic updZ;
   logic updArith;
   logic updC;
   logic cRot;
   logic skip;

   always_comb begin
      res = opnd;
      toAcc = 1'b0;
      toReg = 1'b0;
      updZ = 1'b0;
      updArith = 1'b0;
      updC = 1'b0;
      cRot = carry_r;
      skip = 1'b0;
      if (grpByte) begin
         toAcc = !dBit;
         toReg = dBit;
         unique case (fn)
            `MID_F_SYS: begin
               // d=1 stores acc to F-plane, d=0 is R-plane or system
               res = acc_r;
               toAcc = 1'b0;
            end
            `MID_F_CLR: begin
               res = 8'h00;
               updZ = 1'b1;
            end
            `MID_F_SUB, `MID_F_ADD: begin
               res = sum[7:0];
               updZ = 1'b1;
               updArith = 1'b1;
            end
            `MID_F_DEC: begin
               res = decVal;
               updZ = 1'b1;
            end
            `MID_F_IOR: begin
               res = acc_r | opnd;
               updZ = 1'b1;
            end
            `MID_F_AND: begin
               res = acc_r & opnd;
               updZ = 1'b1;
            end
            `MID_F_XOR: begin
               res = acc_r ^ opnd;
               updZ = 1'b1;
            end
            `MID_F_MOVF: begin
               // d=1 is the zero test: flag only, nothing written
               toReg = 1'b0;
               updZ = dBit;
            end
            `MID_F_COM: begin
               res = ~opnd;
               updZ = 1'b1;
            end
            `MID_F_INC: begin
               res = incVal;
               updZ = 1'b1;
            end
            `MID_F_DECSZ: begin
               res = decVal;
               skip = decVal == 8'h00;
            end
            `MID_F_RRF: begin
               res = {carry_r, opnd[7:1]};
               updC = 1'b1;
               cRot = opnd[0];
            end
            `MID_F_RLF: begin
               res = {opnd[6:0], carry_r};
               updC = 1'b1;
               cRot = opnd[7];
            end
            `MID_F_SWAP: begin
               res = {opnd[3:0], opnd[7:4]};
            end
            `MID_F_INCSZ: begin
               res = incVal;
               skip = incVal == 8'h00;
            end
         endcase
      end else if (grpBit) begin
         unique case (bitOp)
            `MID_B_CLR: begin
               res = opnd & ~bitMask;
               toReg = 1'b1;
            end
            `MID_B_SET: begin
               res = opnd | bitMask;
               toReg = 1'b1;
            end
            `MID_B_TSTC: skip = !bitVal;
            `MID_B_TSTS: skip = bitVal;
         endcase
      end else if (grpLit) begin
         toAcc = 1'b1;
         case (fn)
            `MID_L_RETURN_WITH_LITERAL, `MID_L_LOAD_LITERAL_ACC: res = lit;
            `MID_L_IOR: begin
               res = acc_r | lit;
               updZ = 1'b1;
            end
            `MID_L_AND: begin
               res = acc_r & lit;
               updZ = 1'b1;
            end
            `MID_L_ADD, `MID_L_SUB: begin
               res = sum[7:0];
               updZ = 1'b1;
               updArith = 1'b1;
            end
            `MID_L_XOR: begin
               res = acc_r ^ lit;
               updZ = 1'b1;
            end
            default: toAcc = 1'b0;
         endcase
      end
   end

   // ==========================================
   // flow control
   wire taken = exec && (isCall || isJump || isRet || skip);
   wire [11:0] fetchNxt = (isCall || isJump) ? ir_r[11:0]
      : isRet ? stk.top : isTab ? tblPtr : progAddr_r + 12'h001;
   wire [6:0] rdAddrNxt = progData[13:12] == `MID_GRP_BIT
      ? {1'b0, progData[5:0]} : progData[6:0];
   wire [7:0] tabByte = tabHi_r ? {2'b00, progData[13:8]} : progData[7:0];

   assign stk.push = exec && isCall;
   assign stk.pop = exec && isRet;
   assign stk.wrData = progAddr_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_EXEC: begin
            if (isTab) begin
               state_nxt = ST_TABLE;
            end else if (isSleep) begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_TABLE: state_nxt = ST_EXEC;
         ST_SLEEP: begin
            if (wakeUp) begin
               state_nxt = ST_EXEC;
            end
         end
      endcase
   end

   // ==========================================
   // fetch; a table read parks the next word in ir_r while it borrows
   // the program bus for one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_EXEC;
         progAddr_r <= `MID_RST_PC;
         ir_r <= `MID_NOP;
         regRdAddr_r <= 7'h00;
         savePc_r <= `MID_RST_PC;
         tabHi_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (exec) begin
            progAddr_r <= fetchNxt;
            ir_r <= taken ? `MID_NOP : progData;
            regRdAddr_r <= rdAddrNxt;
            savePc_r <= progAddr_r + 12'h001;
            tabHi_r <= ir_r == `MID_TABLE_READ_HIGH;
         end else if (state_r == ST_TABLE) begin
            progAddr_r <= savePc_r;
         end
      end
   end

   // ==========================================
   // accumulator and flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= 8'h00;
         zero_r <= 1'b0;
         carry_r <= 1'b0;
         halfCarry_r <= 1'b0;
      end else begin
         if (state_r == ST_TABLE) begin
            acc_r <= tabByte;
         end else if (exec && toAcc) begin
            acc_r <= res;
         end
         if (exec && updZ) begin
            zero_r <= res == 8'h00;
         end
         if (exec && updArith) begin
            carry_r <= sum[8];
            halfCarry_r <= nib[4];
         end else if (exec && updC) begin
            carry_r <= cRot;
         end
      end
   end

   // ==========================================
   // register file writes, one cycle after execute
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regWrEn_r <= 1'b0;
         regWrAddr_r <= 7'h00;
         regWrData_r <= 8'h00;
         rplWrEn_r <= 1'b0;
         rplWrAddr_r <= 6'h00;
      end else begin
         regWrEn_r <= exec && toReg;
         regWrAddr_r <= grpBit ? {1'b0, ir_r[5:0]} : ir_r[6:0];
         regWrData_r <= res;
         rplWrEn_r <= exec && isMovwr;
         rplWrAddr_r <= ir_r[5:0];
      end
   end

   // ==========================================
   // power and watchdog; a timeout wins over an instruction that sets it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timeoutFlag_r <= `MID_RST_TO;
         powerDownFlag_r <= `MID_RST_PD;
         sleepMode_r <= 1'b0;
         wdtClear_r <= 1'b0;
         globalIrqEnable_r <= 1'b0;
      end else begin
         if (wdtTimeout) begin
            timeoutFlag_r <= 1'b0;
         end else if (exec && (isSleep || isWdt)) begin
            timeoutFlag_r <= 1'b1;
         end
         if (exec && isSleep) begin
            powerDownFlag_r <= 1'b0;
         end else if (exec && isWdt) begin
            powerDownFlag_r <= 1'b1;
         end
         sleepMode_r <= state_nxt == ST_SLEEP;
         wdtClear_r <= exec && isWdt;
         if (exec && ir_r == `MID_INTERRUPT_RETURN) begin
            globalIrqEnable_r <= 1'b1;
         end
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_CALL_PUSH: assert property (
      exec && isCall |-> stk.push && stk.wrData == progAddr_r)
      else $error("call did not push following address");
   AST_JUMP_TARGET: assert property (
      exec && (isCall || isJump) |=> progAddr_r == $past(ir_r[11:0])
      && ir_r == `MID_NOP)
      else $error("branch target not loaded");
   AST_SKIP_NOP: assert property (
      exec && skip |=> ir_r == `MID_NOP ##1 ir_r == $past(progData))
      else $error("skip did not insert a no-op");
   AST_ADD_ACC: assert property (
      exec && grpByte && fn == `MID_F_ADD && !dBit
      |=> acc_r == $past(opnd) + $past(acc_r) && !regWrEn_r)
      else $error("add to acc wrong");
   AST_SUB_CARRY: assert property (
      exec && grpByte && fn == `MID_F_SUB
      |=> carry_r == ($past(opnd) >= $past(acc_r)))
      else $error("subtract carry is not inverted borrow");
   AST_DECSZ_FLAGS: assert property (
      exec && grpByte && fn == `MID_F_DECSZ
      |=> $stable(zero_r) && $stable(carry_r))
      else $error("decrement-skip changed a flag");
   AST_BIT_TEST_SKIP_CLEAR: assert property (
      exec && grpBit && bitOp == `MID_B_TSTC |-> skip == !opnd[bitNum])
      else $error("test-skip-clear decision wrong");
   AST_ANDLIT: assert property (
      exec && grpLit && fn == `MID_L_AND
      |=> acc_r == ($past(acc_r) & $past(lit))
      && zero_r == (acc_r == 8'h00) && $stable(carry_r))
      else $error("literal and wrong");
   AST_TABLE_TWO: assert property (
      exec && isTab |=> state_r == ST_TABLE ##1 state_r == ST_EXEC)
      else $error("table read not two cycles");
   AST_SLEEP: assert property (
      exec && isSleep |=> sleepMode_r && !powerDownFlag_r)
      else $error("power-down not entered");
   AST_WDT: assert property (
      exec && isWdt && !wdtTimeout
      |=> wdtClear_r && timeoutFlag_r && powerDownFlag_r)
      else $error("watchdog restart wrong");

   COV_CALL: cover property (exec && isCall ##2 exec && isRet);
   COV_SKIP: cover property (exec && skip);
   COV_TABLE: cover property (exec && isTab ##2 exec);
   COV_WAKE: cover property (sleepMode_r ##1 !sleepMode_r);
endmodule : mid_core

// File: mid_defs.svh
`ifndef MID_DEFS_SVH
`define MID_DEFS_SVH

// ==========================================
// fixed encodings
`define MID_NOP 14'h0000
`define MID_SLEEP 14'h0003
`define MID_WDTCLR 14'h0004
`define MID_RET 14'h0040
`define MID_INTERRUPT_RETURN 14'h0060
`define MID_TABLE_READ_LOW 14'h0050
`define MID_TABLE_READ_HIGH 14'h0058

// ==========================================
// top two bits
`define MID_GRP_BYTE 2'h0
`define MID_GRP_BIT 2'h1
`define MID_GRP_CALL 2'h2
`define MID_GRP_JUMP 2'h3

// ==========================================
// byte function codes, bits 11..8
`define MID_F_SYS 4'h0
`define MID_F_CLR 4'h1
`define MID_F_SUB 4'h2
`define MID_F_DEC 4'h3
`define MID_F_IOR 4'h4
`define MID_F_AND 4'h5
`define MID_F_XOR 4'h6
`define MID_F_ADD 4'h7
`define MID_F_MOVF 4'h8
`define MID_F_COM 4'h9
`define MID_F_INC 4'ha
`define MID_F_DECSZ 4'hb
`define MID_F_RRF 4'hc
`define MID_F_RLF 4'hd
`define MID_F_SWAP 4'he
`define MID_F_INCSZ 4'hf

// ==========================================
// bit operations, bits 10..9
`define MID_B_CLR 2'h0
`define MID_B_SET 2'h1
`define MID_B_TSTC 2'h2
`define MID_B_TSTS 2'h3

// ==========================================
// literal function codes, bits 11..8
`define MID_L_RETURN_WITH_LITERAL 4'h8
`define MID_L_LOAD_LITERAL_ACC 4'h9
`define MID_L_IOR 4'ha
`define MID_L_AND 4'hb
`define MID_L_ADD 4'hc
`define MID_L_SUB 4'hd
`define MID_L_XOR 4'hf

// ==========================================
// reset values and sizes
`define MID_RST_PC 12'h000
`define MID_RST_TO 1'b1
`define MID_RST_PD 1'b1
`define MID_STACK_DEPTH 8
`define MID_SP_W 3

`endif

// File: mid_mem_model.sv
`timescale 1ns/10ps
module mid_mem_model
   import mid_pkg::*;
(
   input wire logic clk,
   input wire mid_addr_t progAddr,
   output mid_word_t progData,
   input wire logic [6:0] rdAddr,
   output logic [7:0] rdData,
   input wire logic wrEn,
   input wire logic [6:0] wrAddr,
   input wire logic [7:0] wrData,
   input wire logic rplEn,
   input wire logic [5:0] rplAddr
);
   // =====
   // storage
   // unloaded words stay unknown, so a runaway fetch cannot pass quietly
   mid_word_t prog [0:4095];
   logic [7:0] fReg [0:127];
   logic [7:0] rReg [0:63];
   assign progData = prog[progAddr];
   assign rdData = fReg[rdAddr];
   always @(posedge clk) begin
      if (wrEn) begin
         fReg[wrAddr] <= wrData;
      end
      if (rplEn) begin
         rReg[rplAddr] <= wrData;
      end
   end
endmodule : mid_mem_model

// File: mid_pkg.sv
package mid_pkg;
   // ==========================================
   // types
   typedef logic [13:0] mid_word_t;
   typedef logic [11:0] mid_addr_t;
   typedef enum logic [1:0] {ST_EXEC, ST_TABLE, ST_SLEEP} mid_state_t;
endpackage : mid_pkg

// File: mid_stack.sv
`timescale 1ns/10ps
`include "mid_defs.svh"
module mid_stack
   import mid_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   mid_stack_if.mem stk
);
   // ==========================================
   // return address store
   // overflow wraps silently, as a circular stack would
   mid_addr_t mem [`MID_STACK_DEPTH];
   logic [`MID_SP_W-1:0] sp_r;
   mid_addr_t top_r;

   assign stk.top = top_r;

   always_ff @(posedge clk) begin
      if (stk.push) begin
         mem[sp_r] <= stk.wrData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_r <= '0;
         top_r <= `MID_RST_PC;
      end else if (stk.push) begin
         sp_r <= sp_r + 3'h1;
         top_r <= stk.wrData;
      end else if (stk.pop) begin
         sp_r <= sp_r - 3'h1;
         top_r <= mem[sp_r - 3'h2];
      end
   end
endmodule : mid_stack

// File: mid_stack_if.sv
`timescale 1ns/10ps
interface mid_stack_if
   import mid_pkg::*;
();
   logic push;
   logic pop;
   mid_addr_t wrData;
   mid_addr_t top;
   modport core (output push, output pop, output wrData, input top);
   modport mem (input push, input pop, input wrData, output top);
endinterface : mid_stack_if

// File: tb_mid_core.sv
`timescale 1ns/10ps
module tb_mid_core
   import mid_pkg::*;
;
   // =====
   // signals and model state
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   mid_addr_t tblPtr = 12'h3a5;
   logic wakeUp = 1'b0;
   logic wdtTimeout = 1'b0;
   mid_addr_t progAddr_r;
   mid_word_t progData;
   logic [6:0] regRdAddr_r, regWrAddr_r;
   logic [7:0] regRdData, regWrData_r, acc_r;
   logic [5:0] rplWrAddr_r;
   logic regWrEn_r, rplWrEn_r, carry_r, halfCarry_r, zero_r;
   logic timeoutFlag_r, powerDownFlag_r, sleepMode_r;
   logic wdtClear_r, globalIrqEnable_r;
   int err_count = 0;
   int num_checks = 0;
   int cyc, pos, slot, retPos, wdtPulses;
   bit chkSlot = 1'b1;
   logic [7:0] ma = 8'h00;
   logic mc = 1'b0, mdc = 1'b0, mz = 1'b0;
   logic [7:0] fm [0:127];
   logic [7:0] a, k;
   logic [18:0] expQ [$];
   int slotQ [$];
   logic [18:0] got;

   always #5 clk = ~clk;

   mid_core u_dut (
      .clk(clk),
      .rst_n(rst_n),
      .progData(progData),
      .regRdData(regRdData),
      .tblPtr(tblPtr),
      .wakeUp(wakeUp),
      .wdtTimeout(wdtTimeout),
      .progAddr_r(progAddr_r),
      .regRdAddr_r(regRdAddr_r),
      .regWrEn_r(regWrEn_r),
      .regWrAddr_r(regWrAddr_r),
      .regWrData_r(regWrData_r),
      .rplWrEn_r(rplWrEn_r),
      .rplWrAddr_r(rplWrAddr_r),
      .acc_r(acc_r),
      .carry_r(carry_r),
      .halfCarry_r(halfCarry_r),
      .zero_r(zero_r),
      .timeoutFlag_r(timeoutFlag_r),
      .powerDownFlag_r(powerDownFlag_r),
      .sleepMode_r(sleepMode_r),
      .wdtClear_r(wdtClear_r),
      .globalIrqEnable_r(globalIrqEnable_r)
   );

   mid_mem_model u_mem (
      .clk(clk),
      .progAddr(progAddr_r),
      .progData(progData),
      .rdAddr(regRdAddr_r),
      .rdData(regRdData),
      .wrEn(regWrEn_r),
      .wrAddr(regWrAddr_r),
      .wrData(regWrData_r),
      .rplEn(rplWrEn_r),
      .rplAddr(rplWrAddr_r)
   );

   // =====
   // helpers
   function automatic logic [9:0] addf(logic [7:0] x, logic [7:0] y);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, x} + {1'b0, y};
      h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
      return {s[8], h[4], s[7:0]};
   endfunction : addf

   function automatic logic [9:0] subf(logic [7:0] x, logic [7:0] y);
      logic [7:0] d;
      d = x - y;
      return {x >= y, x[3:0] >= y[3:0], d};
   endfunction : subf

   task check(logic [18:0] g, logic [18:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : check

   task tally_and_finish;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task pre(logic [6:0] f, logic [7:0] v);
      fm[f] = v;
      u_mem.fReg[f] = v;
   endtask : pre

   task op(mid_word_t w);
      u_mem.prog[pos] = w;
      pos++;
      slot++;
   endtask : op

   // write strobe of the op at this slot is seen two edges later
   task note(logic r, logic [6:0] f, logic [7:0] v);
      expQ.push_back({r, f, v, mc, mdc, mz});
      slotQ.push_back(chkSlot ? slot + 2 : 0);
   endtask : note

   task st(logic [6:0] f);
      note(1'b0, f, ma);
      op({7'h01, f});
      fm[f] = ma;
   endtask : st

   task enter(mid_addr_t t);
      op({2'h2, t});
      slot++;
      retPos = pos;
      pos = t;
   endtask : enter

   task leave(mid_word_t w);
      op(w);
      slot++;
      pos = retPos;
   endtask : leave

   task litop(int i, logic [7:0] v);
      logic [9:0] r;
      logic [5:0] c;
      r = {mc, mdc, v};
      c = 6'h19;
      case (i)
         0: begin r = addf(ma, v); c = 6'h1c; end
         1: begin r = subf(v, ma); c = 6'h1d; end
         2: begin r[7:0] = ma & v; c = 6'h1b; end
         3: begin r[7:0] = ma | v; c = 6'h1a; end
         4: begin r[7:0] = ma ^ v; c = 6'h1f; end
         default: ;
      endcase
      {mc, mdc, ma} = r;
      if (i < 5) mz = (ma == 8'h00);
      op({c, v});
   endtask : litop

   // a skipped slot holds a store to 7f that must never land
   task byteop(logic [3:0] fn, logic d, logic [6:0] f);
      logic [9:0] r;
      logic [7:0] v;
      logic skip;
      v = fm[f];
      skip = 1'b0;
      r = {mc, mdc, v};
      case (fn)
         4'h7: r = addf(v, ma);
         4'h2: r = subf(v, ma);
         4'hb: begin r[7:0] = v - 8'h01; skip = (r[7:0] == 8'h00); end
         4'hf: begin r[7:0] = v + 8'h01; skip = (r[7:0] == 8'h00); end
         4'hd: r = {v[7], mdc, v[6:0], mc};
         4'hc: r = {v[0], mdc, mc, v[7:1]};
         default: ;
      endcase
      {mc, mdc} = r[9:8];
      if (fn == 4'h7 || fn == 4'h2) mz = (r[7:0] == 8'h00);
      if (d) begin
         note(1'b0, f, r[7:0]);
         fm[f] = r[7:0];
      end else begin
         ma = r[7:0];
      end
      op({2'h0, fn, d, f});
      if (skip) op(14'h00ff);
   endtask : byteop

   task bitop(logic [1:0] kd, logic [2:0] b, logic [5:0] f);
      logic [7:0] v;
      logic skip;
      v = fm[{1'b0, f}];
      skip = (kd == 2'h2) ? !v[b] : (kd == 2'h3) & v[b];
      if (kd < 2'h2) begin
         v[b] = kd[0];
         note(1'b0, {1'b0, f}, v);
         fm[{1'b0, f}] = v;
      end
      op({3'h2, kd, b, f});
      if (skip) op(14'h00ff);
   endtask : bitop

   // =====
   // result watcher
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) cyc <= 0;
      else cyc <= cyc + 1;
   end

   always @(negedge clk) begin
      if (rst_n && wdtClear_r === 1'b1) wdtPulses++;
      if (rst_n && (regWrEn_r === 1'b1 || rplWrEn_r === 1'b1)) begin
         got = {1'b0, regWrAddr_r, regWrData_r, carry_r, halfCarry_r, zero_r};
         if (rplWrEn_r === 1'b1) got[18:11] = {2'h2, rplWrAddr_r};
         if (expQ.size() == 0) begin
            check(got, ~got);
         end else begin
            check(got, expQ.pop_front());
            if (slotQ[0] != 0) check(19'(cyc), 19'(slotQ[0]));
            void'(slotQ.pop_front());
         end
      end
   end

   // =====
   // program and run
   initial begin
      void'($urandom(32'hd347));
      #1;
      for (int i = 0; i < 128; i++) pre(7'(i), 8'($urandom));
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 6; i++) begin
            a = p ? 8'($urandom) : 8'h5a;
            k = p ? 8'($urandom) : 8'h5a;
            litop(5, a);
            litop(i, k);
            st(7'h20 + 7'(i));
         end
      end
      for (int i = 0; i < 8; i++) begin
         litop(5, 8'($urandom));
         byteop(i < 2 ? 4'h7 : (i < 4 ? 4'h2 : (i < 6 ? 4'hd : 4'hc)),
            i[0], 7'h10 + 7'(i));
         if (!i[0]) st(7'h28);
      end
      pre(7'h30, 8'h01);
      pre(7'h31, 8'hff);
      pre(7'h32, 8'h05);
      pre(7'h33, 8'h00);
      byteop(4'hb, 1'b1, 7'h30);
      byteop(4'hf, 1'b0, 7'h31);
      st(7'h21);
      byteop(4'hb, 1'b0, 7'h32);
      st(7'h22);
      byteop(4'hf, 1'b1, 7'h33);
      byteop(4'h8, 1'b0, 7'h36);
      note(1'b1, 7'h15, ma);
      op(14'h0015);
      pre(7'h35, 8'h0a);
      bitop(2'h1, 3'h7, 6'h35);
      bitop(2'h0, 3'h3, 6'h35);
      bitop(2'h2, 3'h3, 6'h35);
      bitop(2'h3, 3'h7, 6'h35);
      bitop(2'h2, 3'h7, 6'h35);
      bitop(2'h3, 3'h0, 6'h35);
      st(7'h23);
      enter(12'h200);
      ma = 8'h3c;
      leave(14'h183c);
      st(7'h24);
      enter(12'h210);
      litop(5, 8'h11);
      leave(14'h0040);
      st(7'h25);
      enter(12'h220);
      leave(14'h0060);
      op(14'h3300);
      pos = 12'h300;
      slot++;
      u_mem.prog[12'h3a5] = 14'h2b6c;
      op(14'h0058);
      slot++;
      ma = 8'h2b;
      st(7'h26);
      op(14'h0050);
      slot++;
      ma = 8'h6c;
      st(7'h27);
      op(14'h0004);
      op(14'h0003);
      chkSlot = 1'b0;
      litop(5, 8'h77);
      st(7'h2a);
      op(14'h3000 | 14'(pos));
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 1000 && sleepMode_r !== 1'b1; i++) @(negedge clk);
      check(19'(sleepMode_r), 19'h1);
      if (sleepMode_r !== 1'b1) tally_and_finish();
      check(19'({timeoutFlag_r, powerDownFlag_r}), 19'h2);
      check(19'(globalIrqEnable_r), 19'h1);
      check(19'(wdtPulses), 19'h1);
      repeat (3) @(negedge clk);
      // only the store after the parked literal load is still owed
      check(19'({sleepMode_r, expQ.size() == 1}), 19'h3);
      wakeUp = 1'b1;
      @(negedge clk);
      wakeUp = 1'b0;
      for (int i = 0; i < 50 && expQ.size() != 0; i++) @(negedge clk);
      check(19'(expQ.size()), 19'h0);
      wdtTimeout = 1'b1;
      @(negedge clk);
      wdtTimeout = 1'b0;
      @(negedge clk);
      check(19'(timeoutFlag_r), 19'h0);
      tally_and_finish();
   end
endmodule : tb_mid_core
